// ---- verilog/sbs_burst_sequencer.sv ----
// burst sequencer of a synchronous dram with its ahb-lite mode registers
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sbs_cfg.svh"

module sbs_burst_sequencer
  import sbs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire sbs_cmd_t    cmd,
  input  wire sbs_col_t    cmd_col,
  output logic             acc_valid,
  output logic             acc_write,
  output sbs_col_t         acc_col,
  output logic             dq_oe,
  output logic             rd_valid,
  output sbs_col_t         rd_col
);

  sbs_burst_if bif ();

  sbs_mode_t  mode;
  sbs_state_e state;
  sbs_col_t   start_col;
  sbs_col_t   beat;
  sbs_col_t   mask_q;
  logic       ilv_q;
  logic       page_q;
  logic       last_wr;
  sbs_col_t   last_col;
  logic [`SBS_CNT_W-1:0] cnt_ok;
  logic [`SBS_CNT_W-1:0] cnt_ref;

  logic [`SBS_ADDR_W-1:0] addr_q;
  logic       wr_pend;
  logic       rd_wait;
  logic       sel_go;

  logic [2:0] bl_code;
  logic [2:0] lat_code;
  logic       order_ilv;
  logic       wss;
  logic       bl_ok;
  logic       lat_ok;
  logic       opm_ok;
  logic       mode_ok;
  sbs_col_t   mode_mask;
  sbs_col_t   cmd_mask;
  logic       is_rw;
  logic       go;
  logic       page_cmd;
  logic       last_beat;
  logic [31:0] rd_mux;

  // ---------------- mode decode ----------------
  always_comb begin
    bl_code   = mode[`SBS_BL_MSB:`SBS_BL_LSB];
    lat_code  = mode[`SBS_LAT_MSB:`SBS_LAT_LSB];
    order_ilv = mode[`SBS_ORDER_BIT];
    wss       = mode[`SBS_WSS_BIT];
    opm_ok    = ~mode[`SBS_OPM_LO_BIT] & ~mode[`SBS_OPM_HI_BIT];
    lat_ok    = (lat_code == `SBS_LAT_2) || (lat_code == `SBS_LAT_3);
    bl_ok     = 1'b1;
    case (bl_code)
      `SBS_BL_1: mode_mask = `SBS_MASK_1;
      `SBS_BL_2: mode_mask = `SBS_MASK_2;
      `SBS_BL_4: mode_mask = `SBS_MASK_4;
      `SBS_BL_8: mode_mask = `SBS_MASK_8;
      `SBS_BL_PAGE: begin
        mode_mask = `SBS_MASK_PAGE;
        bl_ok     = ~order_ilv;
      end
      default: begin
        mode_mask = `SBS_MASK_1;
        bl_ok     = 1'b0;
      end
    endcase
    // reserved settings stop new bursts instead of guessing a behaviour
    mode_ok = bl_ok & lat_ok & opm_ok;
  end

  // ---------------- command decode ----------------
  always_comb begin
    is_rw = (cmd == `SBS_CMD_READ) || (cmd == `SBS_CMD_WRITE);
    go    = is_rw & mode_ok;
    if ((cmd == `SBS_CMD_WRITE) && wss) begin
      cmd_mask = `SBS_MASK_1;
    end else begin
      cmd_mask = mode_mask;
    end
    page_cmd  = (cmd_mask == `SBS_MASK_PAGE);
    last_beat = (beat == mask_q) && !page_q;
  end

  // ---------------- burst state ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SBS_IDLE;
    end else if (go) begin
      // a new command cuts any burst in progress
      if (cmd_mask == `SBS_MASK_1) begin
        state <= SBS_IDLE;
      end else begin
        state <= SBS_BURST;
      end
    end else if (cmd == `SBS_CMD_TERM) begin
      state <= SBS_IDLE;
    end else begin
      case (state)
        SBS_IDLE:  state <= SBS_IDLE;
        SBS_BURST: begin
          if (last_beat) begin
            state <= SBS_IDLE;
          end
        end
        default:   state <= SBS_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_col <= '0;
      mask_q    <= '0;
      ilv_q     <= 1'b0;
      page_q    <= 1'b0;
      beat      <= '0;
    end else if (go) begin
      start_col <= cmd_col;
      mask_q    <= cmd_mask;
      ilv_q     <= order_ilv;
      page_q    <= page_cmd;
      beat      <= sbs_col_t'(1);
    end else if (state == SBS_BURST) begin
      beat      <= sbs_col_t'(beat + sbs_col_t'(1));
    end
  end

  // beat 0 is the start column in both orders
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_valid <= 1'b0;
      acc_write <= 1'b0;
      acc_col   <= '0;
    end else if (go) begin
      acc_valid <= 1'b1;
      acc_write <= (cmd == `SBS_CMD_WRITE);
      acc_col   <= cmd_col;
    end else if (cmd == `SBS_CMD_TERM) begin
      acc_valid <= 1'b0;
    end else if (state == SBS_BURST) begin
      acc_valid <= 1'b1;
      acc_col   <= bif.col;
    end else begin
      acc_valid <= 1'b0;
    end
  end

  // ---------------- bookkeeping for software ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_wr  <= 1'b0;
      last_col <= '0;
    end else if (go) begin
      last_wr  <= (cmd == `SBS_CMD_WRITE);
      last_col <= cmd_col;
    end
  end

  // counters wrap; they only show activity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ok  <= '0;
      cnt_ref <= '0;
    end else if (go) begin
      cnt_ok  <= cnt_ok + 1'b1;
    end else if (is_rw) begin
      cnt_ref <= cnt_ref + 1'b1;
    end
  end

  // ---------------- carrier wiring ----------------
  assign bif.start_col  = start_col;
  assign bif.beat       = beat;
  assign bif.mask       = mask_q;
  assign bif.interleave = ilv_q;
  assign bif.acc_valid  = acc_valid;
  assign bif.acc_write  = acc_write;
  assign bif.acc_col    = acc_col;
  assign bif.lat3       = (lat_code == `SBS_LAT_3);

  sbs_col_gen u_col_gen (
    .bif (bif)
  );

  sbs_lat_pipe u_lat_pipe (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .bif      (bif),
    .dq_oe    (dq_oe),
    .rd_valid (rd_valid),
    .rd_col   (rd_col)
  );

  // ---------------- ahb-lite slave ----------------
  assign sel_go = hsel & htrans[1] & hready;

  always_comb begin
    rd_mux = '0;
    case (addr_q)
      `SBS_OFF_MODE:   rd_mux[`SBS_MODE_W-1:0] = mode;
      `SBS_OFF_STATUS: begin
        rd_mux[`SBS_ST_BUSY]    = (state == SBS_BURST);
        rd_mux[`SBS_ST_MODE_OK] = mode_ok;
        rd_mux[`SBS_ST_DQ_OE]   = dq_oe;
        rd_mux[`SBS_ST_PAGE]    = page_q & (state == SBS_BURST);
        rd_mux[`SBS_ST_COL_LSB +: `SBS_COL_W] = acc_col;
      end
      `SBS_OFF_LAST: begin
        rd_mux[`SBS_COL_W-1:0]   = last_col;
        rd_mux[`SBS_LAST_WR_BIT] = last_wr;
      end
      `SBS_OFF_COUNT: begin
        rd_mux[`SBS_CNT_W-1:0] = cnt_ok;
        rd_mux[`SBS_CNT_REF_LSB +: `SBS_CNT_W] = cnt_ref;
      end
      default:         rd_mux = '0;
    endcase
  end

  // reads take one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q    <= '0;
      wr_pend   <= 1'b0;
      rd_wait   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= '0;
    end else if (rd_wait) begin
      rd_wait   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= rd_mux;
    end else begin
      wr_pend   <= sel_go & hwrite;
      rd_wait   <= sel_go & ~hwrite;
      hreadyout <= ~(sel_go & ~hwrite);
      if (sel_go) begin
        addr_q <= haddr[`SBS_ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // only whole-word writes are issued; other lanes are not checked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= `SBS_MODE_RST;
    end else if (wr_pend && (addr_q == `SBS_OFF_MODE)) begin
      mode <= hwdata[`SBS_MODE_W-1:0];
    end
  end

endmodule

`default_nettype wire

// ---- inc/sbs_cfg.svh ----
// offsets, field positions, codes and reset values of the burst sequencer
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH

`define SBS_COL_W         10
`define SBS_ADDR_W        8

`define SBS_OFF_MODE      8'h00
`define SBS_OFF_STATUS    8'h04
`define SBS_OFF_LAST      8'h08
`define SBS_OFF_COUNT     8'h0C

`define SBS_BL_LSB        0
`define SBS_BL_MSB        2
`define SBS_ORDER_BIT     3
`define SBS_LAT_LSB       4
`define SBS_LAT_MSB       6
`define SBS_OPM_LO_BIT    7
`define SBS_OPM_HI_BIT    8
`define SBS_WSS_BIT       9
`define SBS_MODE_W        10
`define SBS_MODE_RST      10'h020

`define SBS_BL_1          3'h0
`define SBS_BL_2          3'h1
`define SBS_BL_4          3'h2
`define SBS_BL_8          3'h3
`define SBS_BL_PAGE       3'h7
`define SBS_MASK_1        10'h000
`define SBS_MASK_2        10'h001
`define SBS_MASK_4        10'h003
`define SBS_MASK_8        10'h007
`define SBS_MASK_PAGE     10'h3FF

`define SBS_LAT_2         3'h2
`define SBS_LAT_3         3'h3

`define SBS_CMD_NOP       2'h0
`define SBS_CMD_READ      2'h1
`define SBS_CMD_WRITE     2'h2
`define SBS_CMD_TERM      2'h3

`define SBS_ST_BUSY       0
`define SBS_ST_MODE_OK    1
`define SBS_ST_DQ_OE      2
`define SBS_ST_PAGE       3
`define SBS_ST_COL_LSB    16

`define SBS_LAST_WR_BIT   16
`define SBS_CNT_W         16
`define SBS_CNT_REF_LSB   16

`define SBS_RD_STAGES     3

`endif

// ---- inc/sbs_pkg.sv ----
// types shared by the burst sequencer modules
`include "sbs_cfg.svh"

package sbs_pkg;
  typedef logic [`SBS_COL_W-1:0]  sbs_col_t;
  typedef logic [1:0]             sbs_cmd_t;
  typedef logic [`SBS_MODE_W-1:0] sbs_mode_t;
  typedef enum logic {SBS_IDLE, SBS_BURST} sbs_state_e;
endpackage

// ---- inc/sbs_burst_if.sv ----
// carrier between the sequencer, its column generator and read pipeline
`timescale 1ns/100ps
`default_nettype none

interface sbs_burst_if;
  import sbs_pkg::*;
  sbs_col_t start_col;
  sbs_col_t beat;
  sbs_col_t mask;
  logic     interleave;
  sbs_col_t col;
  logic     acc_valid;
  logic     acc_write;
  sbs_col_t acc_col;
  logic     lat3;

  modport seq  (output start_col, beat, mask, interleave,
                output acc_valid, acc_write, acc_col, lat3,
                input  col);
  modport gen  (input  start_col, beat, mask, interleave,
                output col);
  modport pipe (input  acc_valid, acc_write, acc_col, lat3);
endinterface

`default_nettype wire

// ---- verilog/sbs_col_gen.sv ----
// column of a given beat inside the wrap block
`timescale 1ns/100ps
`default_nettype none

module sbs_col_gen
  import sbs_pkg::*;
(
  sbs_burst_if.gen bif
);

  sbs_col_t offset;

  always_comb begin
    if (bif.interleave) begin
      offset = bif.start_col ^ bif.beat;
    end else begin
      offset = sbs_col_t'(bif.start_col + bif.beat);
    end
    // upper bits keep the block, lower bits wrap inside it
    bif.col = (bif.start_col & ~bif.mask) | (offset & bif.mask);
  end

endmodule

`default_nettype wire

// ---- verilog/sbs_lat_pipe.sv ----
// read latency pipeline: data tokens and output enable timing
`timescale 1ns/100ps
`default_nettype none
`include "sbs_cfg.svh"

module sbs_lat_pipe
  import sbs_pkg::*;
(
  input  wire logic  hclk,
  input  wire logic  hresetn,
  sbs_burst_if.pipe  bif,
  output logic       dq_oe,
  output logic       rd_valid,
  output sbs_col_t   rd_col
);

  logic     stg_v [`SBS_RD_STAGES];
  sbs_col_t stg_c [`SBS_RD_STAGES];

  // stage 0 is the access itself, registered on the command edge
  always_comb begin
    stg_v[0] = bif.acc_valid & ~bif.acc_write;
    stg_c[0] = bif.acc_col;
  end

  genvar k;
  generate
    for (k = 1; k < `SBS_RD_STAGES; k++) begin : g_stage
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          stg_v[k] <= 1'b0;
          stg_c[k] <= '0;
        end else begin
          stg_v[k] <= stg_v[k-1];
          stg_c[k] <= stg_c[k-1];
        end
      end
    end
  endgenerate

  // data valid at edge n+m
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_valid <= 1'b0;
      rd_col   <= '0;
    end else if (bif.lat3) begin
      rd_valid <= stg_v[2];
      rd_col   <= stg_c[2];
    end else begin
      rd_valid <= stg_v[1];
      rd_col   <= stg_c[1];
    end
  end

  // drive from edge n+m-1 until the last beat has been shown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_oe <= 1'b0;
    end else if (bif.lat3) begin
      dq_oe <= stg_v[1] | stg_v[2];
    end else begin
      dq_oe <= stg_v[0] | stg_v[1];
    end
  end

endmodule

`default_nettype wire

// ---- testbench/sbs_ctl_model.sv ----
// memory controller model issuing commands to the sequencer
`include "sbs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module sbs_ctl_model
  import sbs_pkg::*;
(
  input  wire logic hclk,
  output sbs_cmd_t  cmd,
  output sbs_col_t  cmd_col
);
  initial begin
    cmd = `SBS_CMD_NOP;
    cmd_col = '0;
  end

  // one command per call; idle column shows the inverse, not a stale copy
  task automatic go(input sbs_cmd_t c, input sbs_col_t col);
    @(posedge hclk);
    cmd <= c;
    cmd_col <= col;
    @(posedge hclk);
    cmd <= `SBS_CMD_NOP;
    cmd_col <= ~col;
  endtask
endmodule

`default_nettype wire

// ---- testbench/sbs_burst_sequencer_chk.sv ----
// port assertions of the burst sequencer
`include "sbs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module sbs_chk
  import sbs_pkg::*;
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire sbs_cmd_t   cmd,
  input wire sbs_col_t   cmd_col,
  input wire logic       acc_valid,
  input wire logic       acc_write,
  input wire sbs_col_t   acc_col,
  input wire logic       dq_oe,
  input wire logic       rd_valid,
  input wire sbs_col_t   rd_col
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire logic tk = hsel && htrans[1] && hready;

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_zero: assert property (tk && hwrite |=> hreadyout)
    else $error("write stalled");
  a_beat_start: assert property ((cmd[1] ^ cmd[0]) ##1 acc_valid |->
    acc_col == $past(cmd_col) && acc_write == $past(cmd[1]))
    else $error("first beat column wrong");
  a_term_stop: assert property (cmd == `SBS_CMD_TERM |=> !acc_valid)
    else $error("access after terminate");
  a_read_lat: assert property (rd_valid |->
    ($past(acc_valid && !acc_write, 2) && $past(acc_col, 2) == rd_col) ||
    ($past(acc_valid && !acc_write, 3) && $past(acc_col, 3) == rd_col))
    else $error("read beat latency wrong");
  a_oe_lead: assert property ($rose(rd_valid) |-> $past(dq_oe))
    else $error("data lines not driven early");
  a_oe_cover: assert property (rd_valid |-> dq_oe)
    else $error("read beat without drive");
  a_oe_bound: assert property (dq_oe && !rd_valid |=> rd_valid)
    else $error("drive without data");
endmodule

bind sbs_burst_sequencer sbs_chk u_chk (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .cmd, .cmd_col, .acc_valid,
  .acc_write, .acc_col, .dq_oe, .rd_valid, .rd_col);

`default_nettype wire

// ---- testbench/test_sbs_burst_sequencer.sv ----
// self-checking bench of the burst sequencer
`include "sbs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module test_sbs_burst_sequencer
  import sbs_pkg::*;
();
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, v;
  logic        acc_valid, acc_write, dq_oe, rd_valid;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rv, md;
  sbs_cmd_t    cmd;
  sbs_col_t    cmd_col, acc_col, rd_col;
  sbs_col_t    aq[$], rq[$];
  int          at, rt, cyc, l, bad_count, cmp_count;

  sbs_burst_sequencer DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .cmd, .cmd_col, .acc_valid, .acc_write, .acc_col, .dq_oe, .rd_valid,
    .rd_col);
  sbs_ctl_model u_ctl (.hclk, .cmd, .cmd_col);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (acc_valid === 1'b1) begin
      if (aq.size() == 0) at = cyc;
      aq.push_back(acc_col);
    end
    if (rd_valid === 1'b1) begin
      if (rq.size() == 0) rt = cyc;
      rq.push_back(rd_col);
    end
  end

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  function automatic sbs_col_t ecol(sbs_col_t s, int i, int b, logic o);
    sbs_col_t m;
    sbs_col_t k;
    m = sbs_col_t'(b - 1);
    k = sbs_col_t'(i);
    return (s & ~m) | (o ? ((s & m) ^ k) : ((s + k) & m));
  endfunction

  // n beats expected inside a block of b; a page burst is cut after four beats
  task automatic burst(input sbs_cmd_t c, input sbs_col_t s, input int n,
                       input int b, input logic o, input int m);
    aq.delete();
    rq.delete();
    u_ctl.go(c, s);
    if (b == 1024) begin
      repeat (2) @(posedge hclk);
      u_ctl.go(`SBS_CMD_TERM, s);
    end
    repeat (14) @(posedge hclk);
    chk("beats", aq.size(), n);
    for (int i = 0; i < n; i++) begin
      chk("acc col", aq[i], ecol(s, i, b, o));
      if (c == `SBS_CMD_READ) chk("rd col", rq[i], ecol(s, i, b, o));
    end
    chk("rd beats", rq.size(), c == `SBS_CMD_READ ? n : 0);
    if (c == `SBS_CMD_READ && n > 0) chk("latency", rt - at, m);
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = '0;
    hwdata = '0;
    cyc = 0;
    bad_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `SBS_OFF_MODE, '0);
    chk("mode rst", rv, 32'h0000_0020);
    ahb(1'b0, 32'h0000_0010, '0);
    chk("unmapped", rv, '0);
    $display("test reset done");
    // both orders, lengths 1 to 8; writes single when order bit set
    for (int b = 0; b < 8; b++) begin
      v = b[2];
      l = 1 << b[1:0];
      md = {v, 2'h0, 2'h1, v, v, 1'b0, b[1:0]};
      ahb(1'b1, `SBS_OFF_MODE, md);
      burst(`SBS_CMD_READ, 10'h2F5, l, l, v, 2 + v);
      burst(`SBS_CMD_WRITE, 10'h2F5, v ? 1 : l, v ? 1 : l, v, 0);
    end
    ahb(1'b0, `SBS_OFF_LAST, '0);
    chk("last", rv, 32'h0001_02F5);
    $display("test orders done");
    ahb(1'b1, `SBS_OFF_MODE, 32'h0000_0027);
    ahb(1'b0, `SBS_OFF_STATUS, '0);
    chk("status", rv, 32'h02F5_0002);
    burst(`SBS_CMD_READ, 10'h3FE, 4, 1024, 1'b0, 2);
    $display("test page done");
    ahb(1'b1, `SBS_OFF_MODE, 32'h0000_002F);
    burst(`SBS_CMD_READ, 10'h100, 0, 1, 1'b0, 2);
    ahb(1'b1, `SBS_OFF_MODE, 32'h0000_00A0);
    burst(`SBS_CMD_READ, 10'h100, 0, 1, 1'b0, 2);
    ahb(1'b0, `SBS_OFF_COUNT, '0);
    chk("count", rv, 32'h0002_0011);
    ahb(1'b0, `SBS_OFF_LAST, '0);
    chk("last page", rv, 32'h0000_03FE);
    ahb(1'b0, `SBS_OFF_STATUS, '0);
    chk("status off", rv, 32'h0001_0000);
    $display("test refuse done");
    stop_test();
  end
endmodule

`default_nettype wire
